//--- logic/fhcp_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fhcp_map.svh"

module fhcp_top
  import fhcp_pkg::*;
#(
  parameter int NUM_FIFO = 8,
  parameter int DEPTH = 256,
  parameter bit SMALL_MEM = 1'b0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // host register port
  input wire logic host_rd_stb,
  input wire logic host_wr_stb,
  input wire fhcp_host_req_t host_req,
  output logic [31:0] host_rdata,
  output logic host_rvalid,
  // channel side, receive fifos are filled
  input wire logic ch_push,
  input wire logic [$clog2(NUM_FIFO)-1:0] ch_push_fifo,
  input wire logic [7:0] ch_push_data,
  input wire logic ch_push_frame_end,
  output logic ch_push_ready,
  // channel side, transmit fifos are drained
  input wire logic ch_pop,
  input wire logic [$clog2(NUM_FIFO)-1:0] ch_pop_fifo,
  input wire logic ch_pop_frame_end,
  output logic ch_pop_ready,
  output logic [7:0] ch_pop_data,
  output logic ch_pop_valid,
  // status
  output logic [NUM_FIFO-1:0] lost_flags,
  output logic [NUM_FIFO*8-1:0] chan_mask_flat
);
  localparam int FW = $clog2(NUM_FIFO);
  localparam int AW = $clog2(DEPTH);
  localparam logic [15:0] ZMAX = 16'(DEPTH - 1);
  // frame counters wrap to zero after FRM_MAX: 31, or 15 with SMALL_MEM
  localparam logic [4:0] FRM_MAX = SMALL_MEM ? `FHCP_FRM_MAX_SMALL
                                             : `FHCP_FRM_MAX_BIG;

  logic [15:0] in_ptr_reg [NUM_FIFO];
  logic [15:0] out_ptr_reg [NUM_FIFO];
  logic [4:0] in_frm_reg [NUM_FIFO];
  logic [4:0] out_frm_reg [NUM_FIFO];
  logic [7:0] mask_reg [NUM_FIFO];
  logic [NUM_FIFO-1:0] lost_reg;
  logic [FW-1:0] sel_reg;
  logic [31:0] prefetch_reg;
  logic prefetch_load_reg;
  logic [31:0] rdata_reg;
  logic rvalid_reg;
  logic [7:0] pop_data_reg;
  logic pop_valid_reg;

  function automatic logic [4:0] frm_step(input logic [4:0] c);
    return (c >= FRM_MAX) ? 5'h00 : c + 5'h01;
  endfunction

  // lanes beyond the access width read as zero, not as memory
  function automatic logic [31:0] lane_mask(input fhcp_size_t s);
    logic [31:0] m;
    m = 32'h0000_00FF;
    if (s == FHCP_SZ_WORD) m = 32'h0000_FFFF;
    if (s == FHCP_SZ_DWORD) m = 32'hFFFF_FFFF;
    return m;
  endfunction

  // host bus decode
  wire [7:0] addr = host_req.addr;
  wire fhcp_size_t size = host_req.size;
  wire [31:0] wdata = host_req.wdata;
  wire [2:0] nbytes = fhcp_nbytes(size);
  wire at_inc = (addr == `FHCP_OFS_DATA_INC);
  wire at_hold = (addr == `FHCP_OFS_DATA_HOLD);
  wire at_data = at_inc || at_hold;
  wire data_rd = host_rd_stb && at_data;
  wire data_wr = host_wr_stb && at_data;
  wire sel_wr = host_wr_stb && (addr == `FHCP_OFS_FIFO_SEL);
  wire ctl_wr = host_wr_stb && (addr == `FHCP_OFS_STEP_CTL);
  wire mask_wr = host_wr_stb && (addr == `FHCP_OFS_CH_MASK);
  // the reserved upper control bits are ignored, not checked
  wire step_cmd = ctl_wr && wdata[`FHCP_BIT_STEP];
  wire clear_cmd = ctl_wr && wdata[`FHCP_BIT_CLEAR];
  wire lost_clr_cmd = ctl_wr && wdata[`FHCP_BIT_LOST_CLR];
  // even fifos transmit, odd fifos receive
  wire sel_is_rx = sel_reg[0];

  wire [15:0] sel_in_ptr = in_ptr_reg[sel_reg];
  wire [15:0] sel_out_ptr = out_ptr_reg[sel_reg];
  wire [7:0] sel_in_frm = {3'h0, in_frm_reg[sel_reg]};
  wire [7:0] sel_out_frm = {3'h0, out_frm_reg[sel_reg]};

  // host reads at the output pointer, writes at the input pointer
  wire [15:0] rd_ptr_next = fhcp_ptr_adv(sel_out_ptr, nbytes, ZMAX);
  wire [15:0] wr_ptr_next = fhcp_ptr_adv(sel_in_ptr, nbytes, ZMAX);

  // channel side
  wire [15:0] push_in = in_ptr_reg[ch_push_fifo];
  wire [15:0] push_out = out_ptr_reg[ch_push_fifo];
  wire [15:0] push_next = fhcp_ptr_adv(push_in, 3'h1, ZMAX);
  // one slot stays unused so that full and empty can be told apart
  wire push_full = (push_next == push_out);
  wire push_en = |mask_reg[ch_push_fifo];
  wire [15:0] pop_in = in_ptr_reg[ch_pop_fifo];
  wire [15:0] pop_out = out_ptr_reg[ch_pop_fifo];
  wire pop_empty = (pop_in == pop_out);
  wire [15:0] pop_next = fhcp_ptr_adv(pop_out, 3'h1, ZMAX);
  wire pop_en = |mask_reg[ch_pop_fifo];

  // host accesses to the same pointer stall the channel for that cycle
  assign ch_push_ready = !((data_wr || clear_cmd) && (sel_reg == ch_push_fifo));
  assign ch_pop_ready = !((data_rd || clear_cmd) && (sel_reg == ch_pop_fifo));
  // a stalled byte is not taken; the channel must offer it again
  wire push_take = ch_push && ch_push_ready && push_en;
  wire push_store = push_take && !push_full;
  wire pop_take = ch_pop && ch_pop_ready && pop_en;

  // channel events, named once for the per-fifo updates below
  wire push_frm_end = push_take && ch_push_frame_end;
  wire pop_frm_end = pop_take && ch_pop_frame_end;
  wire pop_step = pop_take && !pop_empty;
  wire push_lost = push_take && push_full;

  wire [31:0] mem_hr_data;
  wire [7:0] mem_cr_data;

  fhcp_mem #(
    .NUM_FIFO(NUM_FIFO),
    .DEPTH(DEPTH),
    .FW(FW),
    .AW(AW)
  ) u_mem (
    .ref_clk(ref_clk),
    .hw_en(data_wr),
    .hw_fifo(sel_reg),
    .hw_ofs(sel_in_ptr[AW-1:0]),
    .hw_n(nbytes),
    .hw_data(wdata),
    .cw_en(push_store),
    .cw_fifo(ch_push_fifo),
    .cw_ofs(push_in[AW-1:0]),
    .cw_data(ch_push_data),
    .hr_fifo(sel_reg),
    .hr_ofs(sel_out_ptr[AW-1:0]),
    .hr_data(mem_hr_data),
    .cr_fifo(ch_pop_fifo),
    .cr_ofs(pop_out[AW-1:0]),
    .cr_data(mem_cr_data)
  );

  // read data selection by location and width
  function automatic logic [31:0] rd_mux(input logic [7:0] a,
                                         input fhcp_size_t s);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      `FHCP_OFS_IN_PTR_LO: begin
        if (s == FHCP_SZ_DWORD) r = {sel_out_ptr, sel_in_ptr};
        else if (s == FHCP_SZ_WORD) r = {16'h0000, sel_in_ptr};
        else r = {24'h00_0000, sel_in_ptr[7:0]};
      end
      `FHCP_OFS_IN_PTR_HI: r = {24'h00_0000, sel_in_ptr[15:8]};
      `FHCP_OFS_OUT_PTR_LO: begin
        if (s == FHCP_SZ_BYTE) r = {24'h00_0000, sel_out_ptr[7:0]};
        else r = {16'h0000, sel_out_ptr};
      end
      `FHCP_OFS_OUT_PTR_HI: r = {24'h00_0000, sel_out_ptr[15:8]};
      `FHCP_OFS_FRM_IN: begin
        if (s == FHCP_SZ_BYTE) r = {24'h00_0000, sel_in_frm};
        else r = {16'h0000, sel_out_frm, sel_in_frm};
      end
      `FHCP_OFS_FRM_OUT: r = {24'h00_0000, sel_out_frm};
      `FHCP_OFS_DATA_INC, `FHCP_OFS_DATA_HOLD: begin
        r = mem_hr_data & lane_mask(s);
      end
      `FHCP_OFS_SHORT_RD: r = {24'h00_0000, prefetch_reg[7:0]};
      `FHCP_OFS_LOST_STAT: r = 32'(lost_reg);
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // a process, so the pointer and memory reads inside the function
  // count towards its sensitivity, which a plain assign would miss
  logic [31:0] rd_value;
  always_comb begin
    rd_value = rd_mux(addr, size);
  end

  // one answer per read strobe; data holds until the next read
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_reg <= 32'h0000_0000;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= host_rd_stb;
      if (host_rd_stb) rdata_reg <= rd_value;
    end
  end

  // fifo selection; every rewrite reloads the prefetch buffer
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sel_reg <= FW'(`FHCP_SEL_RST);
      prefetch_load_reg <= 1'b0;
      prefetch_reg <= 32'h0000_0000;
    end else begin
      if (sel_wr) sel_reg <= wdata[FW-1:0];
      prefetch_load_reg <= sel_wr || data_rd;
      // only the low byte shows at 0x88; stale until a reselect or read
      // loads a cycle late so the new selection and pointer apply
      if (prefetch_load_reg) prefetch_reg <= mem_hr_data;
    end
  end

  // input pointers: host writes and channel pushes
  always_ff @(posedge ref_clk) begin
    for (int f = 0; f < NUM_FIFO; f++) begin
      if (reset || (clear_cmd && sel_reg == FW'(f))) begin
        in_ptr_reg[f] <= `FHCP_PTR_RST;
      end else if (data_wr && at_inc && sel_reg == FW'(f)) begin
        in_ptr_reg[f] <= wr_ptr_next;
      end else if (push_store && ch_push_fifo == FW'(f)) begin
        in_ptr_reg[f] <= push_next;
      end
    end
  end

  // writes at the hold location store without moving the pointer

  // output pointers: host reads at either location, channel pops
  always_ff @(posedge ref_clk) begin
    for (int f = 0; f < NUM_FIFO; f++) begin
      if (reset || (clear_cmd && sel_reg == FW'(f))) begin
        out_ptr_reg[f] <= `FHCP_PTR_RST;
      end else if (data_rd && sel_reg == FW'(f)) begin
        out_ptr_reg[f] <= rd_ptr_next;
      end else if (pop_step && ch_pop_fifo == FW'(f)) begin
        out_ptr_reg[f] <= pop_next;
      end
    end
  end

  // an empty transmit fifo keeps returning the byte at its pointer,
  // which is the last byte stored through the hold location
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pop_data_reg <= 8'h00;
      pop_valid_reg <= 1'b0;
    end else begin
      pop_valid_reg <= pop_take;
      if (pop_take) pop_data_reg <= mem_cr_data;
    end
  end

  // pointer reads show live values; they are not kept per frame
  // frame counters; host steps the side it owns, channel the other
  always_ff @(posedge ref_clk) begin
    for (int f = 0; f < NUM_FIFO; f++) begin
      if (reset || (clear_cmd && sel_reg == FW'(f))) begin
        in_frm_reg[f] <= `FHCP_FRM_RST;
        out_frm_reg[f] <= `FHCP_FRM_RST;
      end else begin
        if (step_cmd && !sel_is_rx && sel_reg == FW'(f)) begin
          in_frm_reg[f] <= frm_step(in_frm_reg[f]);
        end else if (push_frm_end && ch_push_fifo == FW'(f)) begin
          in_frm_reg[f] <= frm_step(in_frm_reg[f]);
        end
        if (step_cmd && sel_is_rx && sel_reg == FW'(f)) begin
          out_frm_reg[f] <= frm_step(out_frm_reg[f]);
        end else if (pop_frm_end && ch_pop_fifo == FW'(f)) begin
          out_frm_reg[f] <= frm_step(out_frm_reg[f]);
        end
      end
    end
  end

  // channel mask: zero blocks the channel side of that fifo
  // traffic to a blocked fifo is dropped with no flag raised
  always_ff @(posedge ref_clk) begin
    for (int f = 0; f < NUM_FIFO; f++) begin
      if (reset || (clear_cmd && sel_reg == FW'(f))) begin
        mask_reg[f] <= `FHCP_MASK_RST;
      end else if (mask_wr && sel_reg == FW'(f)) begin
        mask_reg[f] <= wdata[7:0];
      end
    end
  end

  // lost flag: overflowing push sets it, set beats a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    for (int f = 0; f < NUM_FIFO; f++) begin
      if (reset) begin
        lost_reg[f] <= 1'b0;
      end else if (push_lost && ch_push_fifo == FW'(f)) begin
        lost_reg[f] <= 1'b1;
      end else if (lost_clr_cmd && sel_reg == FW'(f)) begin
        lost_reg[f] <= 1'b0;
      end
    end
  end

  // outputs
  assign host_rdata = rdata_reg;
  assign host_rvalid = rvalid_reg;
  assign ch_pop_data = pop_data_reg;
  assign ch_pop_valid = pop_valid_reg;
  assign lost_flags = lost_reg;

  always_comb begin
    for (int f = 0; f < NUM_FIFO; f++) begin
      chan_mask_flat[8*f +: 8] = mask_reg[f];
    end
  end

endmodule
`default_nettype wire

//--- logic/fhcp_map.svh
`ifndef FHCP_MAP_SVH
`define FHCP_MAP_SVH

// register locations on the host bus
`define FHCP_OFS_IN_PTR_LO 8'h04
`define FHCP_OFS_IN_PTR_HI 8'h05
`define FHCP_OFS_OUT_PTR_LO 8'h06
`define FHCP_OFS_OUT_PTR_HI 8'h07
`define FHCP_OFS_FRM_IN 8'h0C
`define FHCP_OFS_FRM_OUT 8'h0D
`define FHCP_OFS_STEP_CTL 8'h0E
`define FHCP_OFS_FIFO_SEL 8'h0F
`define FHCP_OFS_DATA_INC 8'h80
`define FHCP_OFS_DATA_HOLD 8'h84
`define FHCP_OFS_SHORT_RD 8'h88
`define FHCP_OFS_CH_MASK 8'h90
`define FHCP_OFS_LOST_STAT 8'h94

// fifo_step_clear_ctl bit positions
`define FHCP_BIT_STEP 0
`define FHCP_BIT_CLEAR 1
`define FHCP_BIT_LOST_CLR 2

// reset values and limits
`define FHCP_PTR_RST 16'h0000
`define FHCP_FRM_RST 5'h00
`define FHCP_FRM_MAX_BIG 5'h1F
`define FHCP_FRM_MAX_SMALL 5'h0F
`define FHCP_MASK_RST 8'h00
`define FHCP_SEL_RST 4'h0

`endif

//--- logic/fhcp_pkg.sv
package fhcp_pkg;

  typedef enum logic [1:0] {
    FHCP_SZ_BYTE,
    FHCP_SZ_WORD,
    FHCP_SZ_DWORD
  } fhcp_size_t;

  typedef struct packed {
    logic [7:0] addr;
    fhcp_size_t size;
    logic [31:0] wdata;
  } fhcp_host_req_t;

  function automatic logic [2:0] fhcp_nbytes(input fhcp_size_t s);
    logic [2:0] n;
    n = 3'h1;
    if (s == FHCP_SZ_WORD) n = 3'h2;
    if (s == FHCP_SZ_DWORD) n = 3'h4;
    return n;
  endfunction

  // pointer step with wrap from the top of the fifo back to zero
  function automatic logic [15:0] fhcp_ptr_adv(input logic [15:0] p,
                                               input logic [2:0] n,
                                               input logic [15:0] zmax);
    logic [16:0] s;
    s = {1'b0, p} + {14'h0000, n};
    if (s > {1'b0, zmax}) s = s - {1'b0, zmax} - 17'h0_0001;
    return s[15:0];
  endfunction

endpackage

//--- logic/fhcp_mem.sv
`timescale 1ns/1ps
`default_nettype none
module fhcp_mem #(
  parameter int NUM_FIFO = 8,
  parameter int DEPTH = 256,
  parameter int FW = 3,
  parameter int AW = 8
) (
  // clock
  input wire logic ref_clk,
  // host write, up to four bytes
  input wire logic hw_en,
  input wire logic [FW-1:0] hw_fifo,
  input wire logic [AW-1:0] hw_ofs,
  input wire logic [2:0] hw_n,
  input wire logic [31:0] hw_data,
  // channel write, one byte
  input wire logic cw_en,
  input wire logic [FW-1:0] cw_fifo,
  input wire logic [AW-1:0] cw_ofs,
  input wire logic [7:0] cw_data,
  // host read, four bytes from the offset upward
  input wire logic [FW-1:0] hr_fifo,
  input wire logic [AW-1:0] hr_ofs,
  output logic [31:0] hr_data,
  // channel read
  input wire logic [FW-1:0] cr_fifo,
  input wire logic [AW-1:0] cr_ofs,
  output logic [7:0] cr_data
);
  logic [7:0] mem [NUM_FIFO*DEPTH];

  // lowest fifo position lands in the lowest byte lane
  always_ff @(posedge ref_clk) begin
    for (int k = 0; k < 4; k++) begin
      if (hw_en && (k < int'(hw_n))) begin
        mem[{hw_fifo, hw_ofs + AW'(k)}] <= hw_data[8*k +: 8];
      end
    end
    if (cw_en) begin
      mem[{cw_fifo, cw_ofs}] <= cw_data;
    end
  end

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      hr_data[8*k +: 8] = mem[{hr_fifo, hr_ofs + AW'(k)}];
    end
  end

  assign cr_data = mem[{cr_fifo, cr_ofs}];
endmodule
`default_nettype wire

//--- tb/fhcp_props.sv
`timescale 1ns/1ps
`default_nettype none
module fhcp_props
  import fhcp_pkg::*;
#(
  parameter int NUM_FIFO = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // host port
  input wire logic host_rd_stb,
  input wire logic host_wr_stb,
  input wire fhcp_host_req_t host_req,
  input wire logic [31:0] host_rdata,
  input wire logic host_rvalid,
  // channel side
  input wire logic ch_push,
  input wire logic [$clog2(NUM_FIFO)-1:0] ch_push_fifo,
  input wire logic ch_push_ready,
  input wire logic ch_pop,
  input wire logic [$clog2(NUM_FIFO)-1:0] ch_pop_fifo,
  input wire logic ch_pop_ready,
  input wire logic ch_pop_valid,
  // status
  input wire logic [NUM_FIFO-1:0] lost_flags,
  input wire logic [NUM_FIFO*8-1:0] chan_mask_flat
);
  logic [$clog2(NUM_FIFO)-1:0] sel_reg;
  wire logic wr_ctl;
  assign wr_ctl = host_wr_stb && host_req.addr == 8'h0E;
  // shadow of the fifo selection, so per-fifo outputs can be indexed
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sel_reg <= '0;
    end else if (host_wr_stb && host_req.addr == 8'h0F) begin
      sel_reg <= host_req.wdata[$clog2(NUM_FIFO)-1:0];
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  AST_RD_ANSWER:
    assert property (host_rd_stb |=> host_rvalid) else $error("read not answered");
  AST_RVALID_CAUSE:
    assert property (host_rvalid |-> $past(host_rd_stb)) else $error("answer without read");
  AST_UNMAPPED:
    assert property (host_rd_stb && host_req.addr == 8'h10 |=> host_rdata == 32'h0000_0000)
      else $error("unmapped read not zero");
  AST_PUSH_BLOCK:
    assert property (host_wr_stb && host_req.addr == 8'h80 && ch_push_fifo == sel_reg
      |-> !ch_push_ready) else $error("push not held off");
  AST_POP_VALID:
    assert property (ch_pop && ch_pop_ready && |chan_mask_flat[ch_pop_fifo*8 +: 8]
      |=> ch_pop_valid) else $error("pop without data");
  AST_POP_BLOCK:
    assert property (host_rd_stb && (host_req.addr == 8'h80 || host_req.addr == 8'h84)
      && ch_pop_fifo == sel_reg |-> !ch_pop_ready) else $error("pop not held off");
  AST_LOST_CLR:
    assert property (wr_ctl && host_req.wdata[2] && !ch_push |=> !lost_flags[sel_reg])
      else $error("lost flag not cleared");
  AST_CLEAR_MASK:
    assert property (wr_ctl && host_req.wdata[1] |=> chan_mask_flat[sel_reg*8 +: 8] == 8'h00)
      else $error("mask not cleared");
  AST_MASK_HOLD:
    assert property (wr_ctl && !host_req.wdata[1] |=> $stable(chan_mask_flat))
      else $error("mask changed by step");
  cover property (wr_ctl && host_req.wdata[1]);
  cover property (host_rd_stb && host_req.size == FHCP_SZ_DWORD);
  cover property (ch_pop_valid);
endmodule
`default_nettype wire

//--- tb/fhcp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fhcp_host_model
  import fhcp_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // host bus
  output var logic rd_stb,
  output var logic wr_stb,
  output var fhcp_host_req_t req,
  input wire logic [31:0] rdata,
  input wire logic rvalid
);
  initial begin
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    req = '0;
  end
  // released request lines show junk, not the last value
  task automatic acc(input logic w, input logic [7:0] a, input fhcp_size_t s,
                     input logic [31:0] d);
    @(posedge ref_clk);
    rd_stb <= !w;
    wr_stb <= w;
    req <= '{a, s, d};
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    wr_stb <= 1'b0;
    req <= fhcp_host_req_t'(~{a, s, d});
  endtask
  task automatic wr(input logic [7:0] a, input fhcp_size_t s, input logic [31:0] d);
    acc(1'b1, a, s, d);
  endtask
  task automatic rd(input logic [7:0] a, input fhcp_size_t s, output logic [31:0] d);
    acc(1'b0, a, s, 32'h0000_0000);
    #1;
    d = (rvalid === 1'b1) ? rdata : 32'hxxxx_xxxx;
  endtask
  // reselect even when already selected, to refresh the prefetch
  task automatic sel(input logic [7:0] f);
    wr(8'h0F, FHCP_SZ_BYTE, {24'h00_0000, f});
  endtask
  // reserved upper control bits always go out as zero
  task automatic ctl(input logic [7:0] c);
    wr(8'h0E, FHCP_SZ_BYTE, {24'h00_0000, c & 8'h07});
  endtask
endmodule
`default_nettype wire

//--- tb/test_fifo_host_counter_data_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_fifo_host_counter_data_port
  import fhcp_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic rd_stb, wr_stb, rvalid, ch_push, ch_pop, push_rdy, pop_rdy, pop_valid;
  fhcp_host_req_t req;
  logic [31:0] rdata;
  logic [2:0] push_fifo = 3'h0;
  logic [7:0] push_data = 8'h00;
  logic [2:0] pop_fifo = 3'h0;
  logic push_end = 1'b0;
  logic pop_end = 1'b0;
  logic [7:0] pop_data, lost;
  logic [63:0] masks;
  int fail_count = 0;
  int check_count = 0;
  always #25 ref_clk = ~ref_clk;
  initial begin
    ch_push = 1'b0;
    ch_pop = 1'b0;
  end
  // small depth keeps pointer wrap reachable in a few accesses
  fhcp_top #(.DEPTH(16)) dut_u (
    .ref_clk(ref_clk), .reset(reset), .host_rd_stb(rd_stb), .host_wr_stb(wr_stb),
    .host_req(req), .host_rdata(rdata), .host_rvalid(rvalid), .ch_push(ch_push),
    .ch_push_fifo(push_fifo), .ch_push_data(push_data), .ch_push_frame_end(push_end),
    .ch_push_ready(push_rdy), .ch_pop(ch_pop), .ch_pop_fifo(pop_fifo), .ch_pop_frame_end(pop_end),
    .ch_pop_ready(pop_rdy), .ch_pop_data(pop_data), .ch_pop_valid(pop_valid),
    .lost_flags(lost), .chan_mask_flat(masks));
  fhcp_host_model host_u (.ref_clk(ref_clk), .rd_stb(rd_stb), .wr_stb(wr_stb), .req(req),
    .rdata(rdata), .rvalid(rvalid));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  task automatic rc(input logic [7:0] a, input fhcp_size_t s, input logic [31:0] e,
                    input string n);
    logic [31:0] d;
    host_u.rd(a, s, d);
    chk(n, e, d);
  endtask
  task automatic t_reset;
    rc(8'h06, FHCP_SZ_WORD, 32'h0000_0000, "out_ptr_word");
    rc(8'h0C, FHCP_SZ_WORD, 32'h0000_0000, "both_frame_counts");
    rc(8'h10, FHCP_SZ_BYTE, 32'h0000_0000, "unmapped");
    $display("t_reset done");
  endtask
  task automatic t_data;
    host_u.sel(8'h00);
    host_u.wr(8'h90, FHCP_SZ_BYTE, 32'h0000_0001);
    host_u.wr(8'h80, FHCP_SZ_BYTE, 32'h0000_0011);
    host_u.wr(8'h80, FHCP_SZ_WORD, 32'h0000_3322);
    host_u.wr(8'h80, FHCP_SZ_DWORD, 32'h7766_5544);
    host_u.wr(8'h84, FHCP_SZ_BYTE, 32'h0000_0088);
    rc(8'h04, FHCP_SZ_BYTE, 32'h0000_0007, "in_ptr_low_byte");
    rc(8'h05, FHCP_SZ_BYTE, 32'h0000_0000, "in_ptr_high_byte");
    host_u.sel(8'h00);
    rc(8'h80, FHCP_SZ_DWORD, 32'h4433_2211, "fifo_dword_port");
    rc(8'h84, FHCP_SZ_WORD, 32'h0000_6655, "fifo_word_port_hold");
    rc(8'h84, FHCP_SZ_BYTE, 32'h0000_0077, "fifo_byte_port_hold");
    rc(8'h04, FHCP_SZ_DWORD, 32'h0007_0007, "both_ptrs_dword");
    rc(8'h06, FHCP_SZ_BYTE, 32'h0000_0007, "out_ptr_low_byte");
    rc(8'h07, FHCP_SZ_BYTE, 32'h0000_0000, "out_ptr_high_byte");
    rc(8'h04, FHCP_SZ_WORD, 32'h0000_0007, "in_ptr_word");
    host_u.sel(8'h00);
    repeat (2) @(posedge ref_clk);
    rc(8'h88, FHCP_SZ_BYTE, 32'h0000_0088, "short_read_buffer");
    repeat (2) begin
      @(posedge ref_clk);
      ch_pop <= 1'b1;
      pop_end <= 1'b1;
      @(posedge ref_clk);
      ch_pop <= 1'b0;
      pop_end <= 1'b0;
      #1;
      chk("ch_pop_data", 32'h0000_0388, {22'h00_0000, pop_rdy, pop_valid, pop_data});
    end
    // a fifo whose mask is zero gives nothing back
    @(posedge ref_clk);
    ch_pop <= 1'b1;
    pop_fifo <= 3'h2;
    @(posedge ref_clk);
    ch_pop <= 1'b0;
    pop_fifo <= 3'h0;
    #1;
    chk("ch_pop_valid", 32'h0000_0000, {31'h0, pop_valid});
    $display("t_data done");
  endtask
  task automatic t_ctl;
    host_u.ctl(8'h01);
    rc(8'h0C, FHCP_SZ_BYTE, 32'h0000_0001, "in_frame_count");
    host_u.ctl(8'h00);
    rc(8'h0C, FHCP_SZ_WORD, 32'h0000_0201, "both_frame_counts");
    rc(8'h0D, FHCP_SZ_BYTE, 32'h0000_0002, "out_frame_count");
    host_u.ctl(8'h02);
    rc(8'h04, FHCP_SZ_DWORD, 32'h0000_0000, "both_ptrs_dword");
    rc(8'h0C, FHCP_SZ_WORD, 32'h0000_0000, "both_frame_counts");
    chk("chan_mask", 32'h0000_0000, {24'h00_0000, masks[7:0]});
    $display("t_ctl done");
  endtask
  task automatic t_wrap;
    for (int i = 1; i <= 32; i++) begin
      host_u.ctl(8'h01);
      if (i >= 31) rc(8'h0C, FHCP_SZ_BYTE, (i == 32) ? 32'h0 : 32'h1F, "in_frame_count");
    end
    host_u.ctl(8'h02);
    for (int j = 0; j < 5; j++) begin
      host_u.wr(8'h80, (j == 3) ? FHCP_SZ_WORD : FHCP_SZ_DWORD, 32'h0000_0000);
    end
    rc(8'h04, FHCP_SZ_WORD, 32'h0000_0002, "in_ptr_word");
    $display("t_wrap done");
  endtask
  task automatic t_lost;
    host_u.sel(8'h01);
    host_u.wr(8'h90, FHCP_SZ_BYTE, 32'h0000_0001);
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      ch_push <= 1'b1;
      push_fifo <= 3'h1;
      push_data <= 8'(i);
      push_end <= (i == 14);
    end
    @(posedge ref_clk);
    ch_push <= 1'b0;
    push_end <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk("lost_flags", 32'h0000_0003, {30'h0, push_rdy, lost[1]});
    rc(8'h94, FHCP_SZ_BYTE, 32'h0000_0002, "lost_stat");
    rc(8'h0C, FHCP_SZ_BYTE, 32'h0000_0001, "in_frame_count");
    host_u.ctl(8'h04);
    @(posedge ref_clk);
    #1;
    chk("lost_flags", 32'h0000_0000, {31'h0, lost[1]});
    $display("t_lost done");
  endtask
  // reset again in mid-run, with pointers and mask away from zero; the lost flag is already cleared by t_lost
  task automatic t_rerun;
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    host_u.sel(8'h01);
    rc(8'h04, FHCP_SZ_DWORD, 32'h0000_0000, "both_ptrs_dword");
    chk("lost_flags", 32'h0000_0000, {24'h00_0000, lost});
    chk("chan_mask", 32'h0000_0000, masks[31:0]);
    $display("t_rerun done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    fail_count++;
    results();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_data();
    t_ctl();
    t_wrap();
    t_lost();
    t_rerun();
    results();
  end
endmodule
bind fhcp_top fhcp_props #(.NUM_FIFO(NUM_FIFO)) chk_u (.ref_clk(ref_clk), .reset(reset),
  .host_rd_stb(host_rd_stb), .host_wr_stb(host_wr_stb), .host_req(host_req),
  .host_rdata(host_rdata), .host_rvalid(host_rvalid), .ch_push(ch_push),
  .ch_push_fifo(ch_push_fifo), .ch_push_ready(ch_push_ready), .ch_pop(ch_pop),
  .ch_pop_fifo(ch_pop_fifo),
  .ch_pop_ready(ch_pop_ready), .ch_pop_valid(ch_pop_valid), .lost_flags(lost_flags),
  .chan_mask_flat(chan_mask_flat));
`default_nettype wire
